// File: design/bar_pkg.sv
// package for the bit alias remapper: address map, transfer sizes, bus carriers
// assumes a 32-bit byte-addressed bus with a one-cycle-or-longer ready handshake
package bar_pkg;
   localparam logic [31:0] BAR_SRAM_BASE = 32'h20000000;
   localparam logic [31:0] BAR_SRAM_ALIAS = 32'h22000000;
   localparam logic [31:0] BAR_PERI_BASE = 32'h40000000;
   localparam logic [31:0] BAR_PERI_ALIAS = 32'h42000000;
   // alias region span: 32 MB alias covers 1 MB of target bytes
   localparam logic [31:0] BAR_ALIAS_MASK = 32'hFE000000;
   localparam int BAR_BYTE_LSB = 5;
   localparam int BAR_BYTE_MSB = 24;
   localparam int BAR_BIT_LSB = 2;
   localparam int BAR_BIT_MSB = 4;
   // transfer size codes
   localparam logic [1:0] BAR_SIZE_BYTE = 2'h0;
   localparam logic [1:0] BAR_SIZE_HALF = 2'h1;
   localparam logic [1:0] BAR_SIZE_WORD = 2'h2;

   typedef struct packed {
      logic valid;
      logic write;
      logic fetch;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bar_req_s;

   typedef struct packed {
      logic hit;
      logic [31:0] addr;
      logic [2:0] bitpos;
   } bar_map_s;
endpackage

// File: design/bar_decode.sv
// alias address decoder: turns an alias word address into target byte and bit
// assumes a purely combinational use by the remapper top
`timescale 1ns/10ps
module bar_decode
   import bar_pkg::*;
(
   // request address and kind
   input wire logic [31:0] ADDR,
   input wire logic FETCH,
   // decoded target
   output bar_map_s MAP,
   output logic FETCH_FAULT
);
   logic in_sram;
   logic in_peri;
   logic [31:0] disp;

   // region test on the alias windows
   assign in_sram = (ADDR & BAR_ALIAS_MASK) == BAR_SRAM_ALIAS;
   assign in_peri = (ADDR & BAR_ALIAS_MASK) == BAR_PERI_ALIAS;

   assign disp = in_peri ? (ADDR - BAR_PERI_ALIAS) : (ADDR - BAR_SRAM_ALIAS);

   always_comb begin
      MAP.hit = (in_sram || in_peri) && !FETCH;
      // sram alias base lands on sram base bit 0
      MAP.addr = (in_peri ? BAR_PERI_BASE : BAR_SRAM_BASE)
         | {12'h000, disp[BAR_BYTE_MSB:BAR_BYTE_LSB]};
      MAP.bitpos = disp[BAR_BIT_MSB:BAR_BIT_LSB];
   end

   // peripheral alias fetch refused; sram alias fetch passes unmapped
   assign FETCH_FAULT = in_peri && FETCH;
endmodule

// File: design/bar_remap.sv
// bit alias remapper: sits between the core load/store master and the target bus
// assumes targets answer with T_READY (may stall) and that T_LOCK holds others off
// assumes the core holds its request unchanged until the C_READY pulse
// one request in flight: an alias write costs two locked target transfers
//
// Behaviour
// - each alias word maps to exactly one target bit, SRAM and peripheral
// - remapped target access keeps the originating transfer width
// - alias displacement is byte offset times 32 plus bit times 4
// - alias address is alias base plus displacement; decode inverts it
// - bit field from alias address picks one of eight bits
// - alias base word decodes to bit 0 of SRAM target base byte
// - alias write sets or clears only the target bit from data bit 0
// - write data bits 31 to 1 are ignored on alias writes
// - alias read returns zero or one, zero-extended
// - SRAM alias data accesses remapped, writes as read-modify-write, fetches not
// - peripheral alias remapped for data, fetches refused
// - direct target accesses pass through unchanged
`timescale 1ns/10ps
module bar_remap
   import bar_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // core side request
   input wire logic C_VALID,
   input wire logic C_WRITE,
   input wire logic C_FETCH,
   input wire logic [1:0] C_SIZE,
   input wire logic [31:0] C_ADDR,
   input wire logic [31:0] C_WDATA,
   // core side answer
   output logic C_READY,
   output logic [31:0] C_RDATA,
   output logic C_ERROR,
   // target side request
   output logic T_VALID,
   output logic T_WRITE,
   output logic [1:0] T_SIZE,
   output logic [31:0] T_ADDR,
   output logic [31:0] T_WDATA,
   output logic T_LOCK,
   // target side answer
   input wire logic T_READY,
   input wire logic [31:0] T_RDATA
);
   typedef enum logic [2:0] {
      BAR_IDLE,
      BAR_PASS,
      BAR_RD,
      BAR_WR,
      BAR_DONE
   } bar_state_e;

   // request and its decode, held for the whole transfer
   bar_state_e state_q;
   bar_req_s req_q;
   bar_map_s map_q;
   bar_map_s map_now;
   logic fault_now;
   logic [31:0] rdata_q;
   logic err_q;
   logic [31:0] lane_mask;
   logic [31:0] lane_bit;
   logic take_now;
   logic rd_done;
   logic [31:0] wback_q;

   // decode from the live address; the result is captured with the request at take
   bar_decode u_decode (
      .ADDR(C_ADDR),
      .FETCH(C_FETCH),
      .MAP(map_now),
      .FETCH_FAULT(fault_now)
   );

   // bit position within the transfer lane: the target byte sits at its byte lane
   function automatic logic [31:0] bar_bit_of(input logic [1:0] lane, input logic [2:0] pos);
      bar_bit_of = 32'h00000001 << {lane, pos};
   endfunction

   assign lane_bit = bar_bit_of(map_q.addr[1:0], map_q.bitpos);
   // one mask serves both the bit read-back and the write-back merge
   assign lane_mask = lane_bit;

   // request accepted: only an idle remapper looks at the core side
   assign take_now = state_q == BAR_IDLE && C_VALID;
   // read phase ends at the target's answer; also where the old word is seen
   assign rd_done = state_q == BAR_RD && T_READY;

   // sequencer; one request in flight, core stalls until C_READY
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= BAR_IDLE;
      end else begin
         unique case (state_q)
            BAR_IDLE: begin
               if (C_VALID) begin
                  if (fault_now) begin
                     state_q <= BAR_DONE;
                  end else if (map_now.hit) begin
                     state_q <= BAR_RD;
                  end else begin
                     state_q <= BAR_PASS;
                  end
               end
            end
            // pass-through: wait for the target's answer
            BAR_PASS: begin
               if (T_READY) begin
                  state_q <= BAR_DONE;
               end
            end
            // alias read phase, locked when a write-back follows
            BAR_RD: begin
               if (T_READY) begin
                  state_q <= req_q.write ? BAR_WR : BAR_DONE;
               end
            end
            // alias write-back phase
            BAR_WR: begin
               if (T_READY) begin
                  state_q <= BAR_DONE;
               end
            end
            // answer cycle: C_READY stands here for one clock
            BAR_DONE: begin
               state_q <= BAR_IDLE;
            end
            // an illegal code falls back to idle rather than holding the bus
            default: begin
               state_q <= BAR_IDLE;
            end
         endcase
      end
   end

   // capture request and its decode when accepted
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         req_q <= '0;
         map_q <= '0;
      end else if (take_now) begin
         req_q <= '{valid: 1'b1,
            write: C_WRITE,
            fetch: C_FETCH,
            size: C_SIZE,
            addr: C_ADDR,
            wdata: C_WDATA};
         map_q <= map_now;
      end
   end

   // read data and error held for the answer cycle
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_q <= '0;
         err_q <= 1'b0;
      end else if (take_now) begin
         err_q <= fault_now;
         // cleared at take so a refused fetch reads as zero
         rdata_q <= '0;
      end else if (state_q == BAR_PASS && T_READY) begin
         rdata_q <= T_RDATA;
      end else if (rd_done) begin
         rdata_q <= {31'h00000000, |(T_RDATA & lane_mask)};
      end
   end

   // merged write-back word
   // built at the read answer so T_WDATA leaves a flip-flop; only the target bit differs
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wback_q <= '0;
      end else if (rd_done) begin
         // only data bit 0 is looked at
         wback_q <= req_q.wdata[0] ? (T_RDATA | lane_mask) : (T_RDATA & ~lane_mask);
      end
   end

   // target request drive
   always_comb begin
      T_VALID = 1'b0;
      T_WRITE = 1'b0;
      T_SIZE = req_q.size;
      T_ADDR = req_q.addr;
      T_WDATA = req_q.wdata;
      T_LOCK = 1'b0;
      unique case (state_q)
         // pass-through: address and data as the core gave them
         BAR_PASS: begin
            T_VALID = 1'b1;
            T_WRITE = req_q.write;
         end
         BAR_RD: begin
            T_VALID = 1'b1;
            T_ADDR = map_q.addr;
            T_LOCK = req_q.write;
         end
         BAR_WR: begin
            T_VALID = 1'b1;
            T_WRITE = 1'b1;
            T_ADDR = map_q.addr;
            T_LOCK = 1'b1;
            // merged word from the read phase
            T_WDATA = wback_q;
         end
         // idle and answer cycles leave the target bus quiet
         default: begin
         end
      endcase
   end

   // core answer: one-cycle ready pulse in the done state
   // decoded from the state register alone, so no path from T_READY reaches it
   assign C_READY = state_q == BAR_DONE;
   assign C_RDATA = rdata_q;
   assign C_ERROR = err_q;
endmodule

// File: verif/bar_target_model.sv
// target memory model: sixteen words, stall of lat cycles per transfer
// assumes each request is held until T_READY
`timescale 1ns/10ps
module bar_target_model
   import bar_pkg::*;
(
   // clock, reset, stall
   input wire logic CORE_CLK, RESETN,
   input wire logic [1:0] lat,
   // target bus
   input wire logic T_VALID, T_WRITE,
   input wire logic [1:0] T_SIZE,
   input wire logic [31:0] T_ADDR, T_WDATA,
   output logic T_READY,
   output logic [31:0] T_RDATA
);
   logic [31:0] mem_q [16];
   logic [1:0] wait_q;
   logic [3:0] idx;
   logic [31:0] lane;
   assign idx = {T_ADDR[30], T_ADDR[4:2]};
   assign lane = T_SIZE == BAR_SIZE_BYTE ? 32'hFF << {T_ADDR[1:0], 3'h0} :
      T_SIZE == BAR_SIZE_HALF ? 32'hFFFF << {T_ADDR[1], 4'h0} : '1;
   assign T_READY = T_VALID && wait_q >= lat;
   // unanswered data shows inverted, never a stale copy
   assign T_RDATA = T_READY ? mem_q[idx] : ~mem_q[idx];
   always_ff @(posedge CORE_CLK or negedge RESETN)
      if (!RESETN) wait_q <= 2'h0;
      else wait_q <= T_VALID && !T_READY ? wait_q + 2'h1 : 2'h0;
   // only the lanes of the transfer size change
   always_ff @(posedge CORE_CLK or negedge RESETN)
      if (!RESETN) mem_q <= '{default: '0};
      else if (T_READY && T_WRITE) mem_q[idx] <= mem_q[idx] & ~lane | T_WDATA & lane;
endmodule

// File: verif/bar_remap_assertions.sv
// port checker for the remapper
// assumes core inputs are held until C_READY
`timescale 1ns/10ps
module bar_remap_assertions
   import bar_pkg::*;
(
   // clock, core side, target side
   input wire logic CORE_CLK, RESETN, C_VALID, C_WRITE, C_FETCH, C_READY, C_ERROR,
   input wire logic [1:0] C_SIZE, T_SIZE,
   input wire logic [31:0] C_ADDR, C_WDATA, C_RDATA, T_ADDR, T_WDATA,
   input wire logic T_VALID, T_WRITE, T_LOCK
);
   logic pa, al;
   logic [31:0] tgt;
   assign pa = C_ADDR[31:25] == 7'h21;
   assign al = (C_ADDR[31:25] == 7'h11 || pa) && !C_FETCH;
   // target byte that an alias word stands for
   assign tgt = (pa ? BAR_PERI_BASE : BAR_SRAM_BASE) | {12'h0, C_ADDR[24:5]};
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   chk_size_kept: assert property (T_VALID |-> T_SIZE == C_SIZE) else $error("size");
   chk_alias_addr: assert property (T_VALID && al |-> T_ADDR == tgt) else $error("alias addr");
   chk_pass_addr: assert property (T_VALID && !al |-> T_ADDR == C_ADDR) else $error("pass addr");
   chk_data_bit: assert property (T_VALID && T_WRITE && al |->
      T_WDATA[{T_ADDR[1:0], C_ADDR[4:2]}] == C_WDATA[0]) else $error("data bit");
   chk_read_first: assert property ($rose(T_WRITE) && al |->
      $past(T_VALID) && $past(T_LOCK) && T_LOCK) else $error("lock");
   chk_read_zext: assert property (C_READY && !C_WRITE && al |-> C_RDATA[31:1] == 31'h0) else $error("rdata");
   chk_fetch_refused: assert property (C_VALID && C_FETCH && pa |-> !T_VALID) else $error("fetch");
   chk_fetch_error: assert property (C_READY && C_FETCH && pa |-> C_ERROR) else $error("no error");
   chk_answer_bound: assert property (
      $rose(C_VALID) && !(C_FETCH && pa) |-> ##[2:40] C_READY) else $error("no answer");
   chk_refusal_quick: assert property (
      $rose(C_VALID) && C_FETCH && pa |-> ##1 C_READY) else $error("slow refusal");
   cov_rmw: cover property (T_WRITE && T_LOCK);
   cov_fault: cover property (C_READY && C_ERROR);
   cov_alias_read: cover property (C_READY && al && !C_WRITE);
endmodule
bind bar_remap bar_remap_assertions bar_remap_assertions_i (
   .CORE_CLK(CORE_CLK),
   .RESETN(RESETN),
   .C_VALID(C_VALID),
   .C_WRITE(C_WRITE),
   .C_FETCH(C_FETCH),
   .C_READY(C_READY),
   .C_ERROR(C_ERROR),
   .C_SIZE(C_SIZE),
   .T_SIZE(T_SIZE),
   .C_ADDR(C_ADDR),
   .C_WDATA(C_WDATA),
   .C_RDATA(C_RDATA),
   .T_ADDR(T_ADDR),
   .T_WDATA(T_WDATA),
   .T_VALID(T_VALID),
   .T_WRITE(T_WRITE),
   .T_LOCK(T_LOCK)
);

// File: verif/bit_alias_remapper_bench.sv
// bench: core-side tasks against the remapper and the target model
// assumes design, model and checker are compiled first
`timescale 1ns/10ps
module bit_alias_remapper_bench;
   import bar_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
   logic CORE_CLK = 0, RESETN = 0, C_VALID = 0, C_WRITE = 0, C_FETCH = 0, C_READY, C_ERROR, err;
   logic T_VALID, T_WRITE, T_LOCK, T_READY;
   logic [1:0] C_SIZE = 0, T_SIZE, lat = 0;
   logic [31:0] C_ADDR = 0, C_WDATA = 0, C_RDATA, T_ADDR, T_WDATA, T_RDATA, rd;
   int errors = 0, comparisons = 0;
   bar_remap bar_remap_i (
      .CORE_CLK(CORE_CLK),
      .RESETN(RESETN),
      .C_VALID(C_VALID),
      .C_WRITE(C_WRITE),
      .C_FETCH(C_FETCH),
      .C_SIZE(C_SIZE),
      .C_ADDR(C_ADDR),
      .C_WDATA(C_WDATA),
      .C_READY(C_READY),
      .C_RDATA(C_RDATA),
      .C_ERROR(C_ERROR),
      .T_VALID(T_VALID),
      .T_WRITE(T_WRITE),
      .T_SIZE(T_SIZE),
      .T_ADDR(T_ADDR),
      .T_WDATA(T_WDATA),
      .T_LOCK(T_LOCK),
      .T_READY(T_READY),
      .T_RDATA(T_RDATA)
   );
   bar_target_model bar_target_model_i (
      .CORE_CLK(CORE_CLK),
      .RESETN(RESETN),
      .lat(lat),
      .T_VALID(T_VALID),
      .T_WRITE(T_WRITE),
      .T_SIZE(T_SIZE),
      .T_ADDR(T_ADDR),
      .T_WDATA(T_WDATA),
      .T_READY(T_READY),
      .T_RDATA(T_RDATA)
   );
   always #50 CORE_CLK = ~CORE_CLK;
   // one core access, held until the ready pulse
   task automatic acc(input logic w, f, input logic [1:0] s, input logic [31:0] a, d);
      int n;
      n = 0;
      {C_VALID, C_WRITE, C_FETCH, C_SIZE, C_ADDR, C_WDATA} = {1'b1, w, f, s, a, d};
      do begin @(posedge CORE_CLK); #1; n++; end while (C_READY !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      {rd, err} = {C_RDATA, C_ERROR};
      @(posedge CORE_CLK);
      #1 C_VALID = 0;
      @(posedge CORE_CLK);
      #1;
   endtask
   task give_verdict;
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task t_direct;
      acc(1, 0, BAR_SIZE_WORD, 32'h20000004, 32'hA5A50F0F);
      acc(0, 0, BAR_SIZE_WORD, 32'h20000004, 0);
      `CHK(rd, 32'hA5A50F0F)
      `CHK(err, 1'b0)
   endtask
   // each bit of byte 6, byte transfers, slow target
   task t_alias_read;
      lat = 2;
      for (int b = 0; b < 8; b++) begin
         acc(0, 0, BAR_SIZE_BYTE, 32'h220000C0 + b * 4, 0);
         `CHK(rd, 32'(8'hA5 >> b & 8'h01))
      end
   endtask
   task t_alias_write;
      lat = 1;
      acc(1, 0, BAR_SIZE_WORD, 32'h22000080, 32'h0000000E);
      acc(1, 0, BAR_SIZE_HALF, 32'h22000090, 32'hFFFFFFF1);
      acc(1, 0, BAR_SIZE_WORD, 32'h22000000, 32'h1);
      acc(0, 0, BAR_SIZE_WORD, 32'h20000004, 0);
      `CHK(rd, 32'hA5A50F1E)
      acc(0, 0, BAR_SIZE_WORD, 32'h20000000, 0);
      `CHK(rd, 32'h1)
      // a fetch from the sram alias is not remapped: it reads the word at the alias address itself
      acc(0, 1, BAR_SIZE_WORD, 32'h22000004, 0);
      `CHK(rd, 32'hA5A50F1E)
      `CHK(err, 1'b0)
   endtask
   task t_peri;
      lat = 0;
      acc(1, 0, BAR_SIZE_WORD, 32'h420000E4, 32'h3);
      acc(0, 0, BAR_SIZE_WORD, 32'h40000004, 0);
      `CHK(rd, 32'h02000000)
      acc(0, 1, BAR_SIZE_WORD, 32'h420000E4, 0);
      `CHK(err, 1'b1)
   endtask
   // watchdog well past the roughly 115 cycles the tests take
   initial begin
      #2000000;
      errors++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge CORE_CLK);
      #1 RESETN = 1;
      @(posedge CORE_CLK);
      #1;
      t_direct;
      t_alias_read;
      t_alias_write;
      t_peri;
      give_verdict;
   end
endmodule
